// File: hw/fcss_ctrl.sv
// Host-side controller that sequences flash commands and interprets status
`timescale 1ns/1ns
`include "fcss_map.svh"
// Overview of operation
// - Erase suspended only when bits 7,6 set
// - Second resume needed to finish erase after nested program suspend
// - Program: setup then address and data
// - Erase: setup then confirm at block
// - Config setup then lock action code
// - Protection program or lock pattern
// - Test ready bit before result bits
// - Mask reserved bit 0 when polling
// - Toggle strobe for every status poll
module fcss_ctrl
   import fcss_pkg::*;
(
   input  wire logic        i_clk,          // 20 MHz clock
   input  wire logic        i_nrst,         // Async reset, active low
   input  wire logic        i_req,          // User request, one pulse
   input  wire logic [3:0]  i_op,           // Operation, fcss_op_e code
   input  wire logic [21:0] i_addr,         // Target word address
   input  wire logic [15:0] i_data,         // Program word
   input  wire logic        i_wait,         // Poll until ready after command
   output logic             o_ready,        // Ready to take a request
   output logic             o_done,         // Request finished, one pulse
   output logic             o_refused,      // Request refused, one pulse
   output logic [15:0]      o_rdata,        // Read data or status
   output logic [7:0]       o_status,       // Last polled status, bit 0 masked
   output logic             o_erase_susp,   // Erase confirmed suspended
   output logic             o_prog_susp,    // Program confirmed suspended
   output logic             o_seq_error,    // Command sequence error seen
   output logic             o_nested,       // Program running in suspended erase
   output logic [21:0]      o_a,            // Flash address pins
   output logic [15:0]      o_dq_out,       // Flash data out
   output logic             o_dq_oe,        // High while driving data
   input  wire logic [15:0] i_dq_in,        // Flash data in
   output logic             o_ce_n,         // Chip enable, active low
   output logic             o_oe_n,         // Output enable, active low
   output logic             o_we_n          // Write enable, active low
);
   // Controller states
   typedef enum logic [2:0] {
      FCSS_ST_IDLE  = 3'b000,
      FCSS_ST_FIRST = 3'b001,
      FCSS_ST_SECND = 3'b010,
      FCSS_ST_POLL  = 3'b011,
      FCSS_ST_FIN   = 3'b100
   } fcss_ctl_e;

   fcss_ctl_e   state;        // Controller state
   fcss_op_e    op;           // Latched operation
   logic [21:0] addr;         // Latched address
   logic [15:0] data;         // Latched data
   logic        wait_rdy;     // Latched poll request
   logic        cyc_start;    // Pulse to bus cycle unit
   logic        cyc_write;    // Direction of that cycle
   logic [21:0] cyc_addr;     // Address of that cycle
   logic [15:0] cyc_wdata;    // Data of that cycle
   logic        cyc_busy;     // Bus cycle running
   logic        cyc_done;     // Bus cycle finished
   logic [15:0] cyc_rdata;    // Data read back
   logic        erase_run;    // Host belief: erase outstanding
   logic        prog_nest;    // Program issued inside suspended erase
   logic [6:0]  erase_blk;    // Block of the outstanding erase

   // First-cycle code for each operation; bare reads issue no write
   function automatic logic [15:0] first_code(input fcss_op_e o);
      case (o)
         FCSS_OP_READ_ARRAY: first_code = {8'h0, `FCSS_CMD_READ_ARRAY};
         FCSS_OP_READ_ID:    first_code = {8'h0, `FCSS_CMD_READ_ID};
         FCSS_OP_QUERY:      first_code = {8'h0, `FCSS_CMD_QUERY};
         FCSS_OP_STATUS:     first_code = {8'h0, `FCSS_CMD_READ_STATUS};
         FCSS_OP_CLEAR:      first_code = {8'h0, `FCSS_CMD_CLEAR_STATUS};
         FCSS_OP_PROGRAM:    first_code = {8'h0, `FCSS_CMD_PROG_SETUP};
         FCSS_OP_ERASE:      first_code = {8'h0, `FCSS_CMD_ERASE_SETUP};
         FCSS_OP_SUSPEND:    first_code = {8'h0, `FCSS_CMD_SUSPEND};
         FCSS_OP_RESUME:     first_code = {8'h0, `FCSS_CMD_CONFIRM};
         FCSS_OP_LOCK,
         FCSS_OP_UNLOCK,
         FCSS_OP_LOCKDOWN:   first_code = {8'h0, `FCSS_CMD_CFG_SETUP};
         FCSS_OP_PROT_PROG,
         FCSS_OP_PROT_LOCK:  first_code = {8'h0, `FCSS_CMD_PROT_SETUP};
         default:            first_code = 16'h0;
      endcase
   endfunction

   // Second-cycle data for two-write sequences
   function automatic logic [15:0] second_code(input fcss_op_e o, input logic [15:0] d);
      case (o)
         FCSS_OP_PROGRAM,
         FCSS_OP_PROT_PROG:  second_code = d;
         FCSS_OP_ERASE,
         FCSS_OP_UNLOCK:     second_code = {8'h0, `FCSS_CMD_CONFIRM};
         FCSS_OP_LOCK:       second_code = {8'h0, `FCSS_CMD_LOCK};
         FCSS_OP_LOCKDOWN:   second_code = {8'h0, `FCSS_CMD_LOCKDOWN};
         FCSS_OP_PROT_LOCK:  second_code = `FCSS_PROT_LOCK_DATA;
         default:            second_code = 16'h0;
      endcase
   endfunction

   // Decode of the request and of the latched operation
   wire fcss_op_e req_op   = fcss_op_e'(i_op);
   wire two_cycle = (op == FCSS_OP_PROGRAM) || (op == FCSS_OP_ERASE) ||
                    (op == FCSS_OP_LOCK) || (op == FCSS_OP_UNLOCK) ||
                    (op == FCSS_OP_LOCKDOWN) || (op == FCSS_OP_PROT_PROG) ||
                    (op == FCSS_OP_PROT_LOCK);
   wire bare_read = (op == FCSS_OP_READ);
   wire engine_op = (op == FCSS_OP_PROGRAM) || (op == FCSS_OP_ERASE) ||
                    (op == FCSS_OP_PROT_PROG) || (op == FCSS_OP_PROT_LOCK);
   wire poll_op   = engine_op || (op == FCSS_OP_SUSPEND) || (op == FCSS_OP_RESUME);
   // Polled status with reserved bit masked; only the low byte carries it
   wire [7:0] poll_st = cyc_rdata[7:0] & `FCSS_STATUS_MASK;
   wire st_ready  = poll_st[`FCSS_BIT_READY];
   // Suspend needs both ready and its suspend bit before it counts
   wire st_esusp  = st_ready & poll_st[`FCSS_BIT_ERASE_SUSP];
   wire st_psusp  = st_ready & poll_st[`FCSS_BIT_PROG_SUSP];
   wire st_seqerr = st_ready & poll_st[`FCSS_BIT_PROG_FAIL] &
                    poll_st[`FCSS_BIT_ERASE_FAIL];
   // Refusals keep the device out of undefined sequences
   wire refuse = ((req_op == FCSS_OP_ERASE) && o_erase_susp) ||
                 ((req_op == FCSS_OP_RESUME) && o_erase_susp && prog_nest &&
                  !o_prog_susp) ||
                 ((req_op == FCSS_OP_PROGRAM) && o_erase_susp &&
                  (i_addr[21:15] == erase_blk)) ||
                 (i_op == 4'hf);
   assign o_ready = (state == FCSS_ST_IDLE);

   // Each poll is its own read cycle, so output enable toggles every time
   always_comb begin
      cyc_start = 1'b0;
      cyc_write = 1'b1;
      cyc_addr  = addr;
      cyc_wdata = first_code(op);
      case (state)
         FCSS_ST_FIRST: begin
            cyc_start = !cyc_busy && !cyc_done;
            cyc_write = !bare_read;
         end
         FCSS_ST_SECND: begin
            cyc_start = !cyc_busy && !cyc_done;
            cyc_wdata = second_code(op, data);
         end
         FCSS_ST_POLL: begin
            cyc_start = !cyc_busy && !cyc_done;
            cyc_write = 1'b0;
         end
         default: cyc_start = 1'b0;
      endcase
   end

   fcss_bus_cycle u_cyc (
      .i_clk    (i_clk),
      .i_nrst   (i_nrst),
      .i_start  (cyc_start),
      .i_write  (cyc_write),
      .i_addr   (cyc_addr),
      .i_wdata  (cyc_wdata),
      .i_dq_in  (i_dq_in),
      .o_busy   (cyc_busy),
      .o_done   (cyc_done),
      .o_rdata  (cyc_rdata),
      .o_a      (o_a),
      .o_dq_out (o_dq_out),
      .o_dq_oe  (o_dq_oe),
      .o_ce_n   (o_ce_n),
      .o_oe_n   (o_oe_n),
      .o_we_n   (o_we_n)
   );

   // Command sequencing and host view of suspension state
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= FCSS_ST_IDLE;
         op <= FCSS_OP_READ_ARRAY;
         addr <= 22'h0;
         data <= 16'h0;
         wait_rdy <= 1'b0;
         o_done <= 1'b0;
         o_refused <= 1'b0;
         o_rdata <= 16'h0;
         o_status <= 8'h0;
         o_erase_susp <= 1'b0;
         o_prog_susp <= 1'b0;
         o_seq_error <= 1'b0;
         erase_run <= 1'b0;
         prog_nest <= 1'b0;
         erase_blk <= 7'h0;
      end else begin
         o_done <= 1'b0;
         o_refused <= 1'b0;
         case (state)
            FCSS_ST_IDLE: begin
               if (i_req && refuse) begin
                  o_refused <= 1'b1;
               end else if (i_req) begin
                  op <= req_op;
                  addr <= i_addr;
                  data <= i_data;
                  wait_rdy <= i_wait;
                  state <= FCSS_ST_FIRST;
               end
            end
            FCSS_ST_FIRST: begin
               if (cyc_done) begin
                  if (bare_read) o_rdata <= cyc_rdata;
                  if (two_cycle) state <= FCSS_ST_SECND;
                  else if (poll_op && wait_rdy) state <= FCSS_ST_POLL;
                  else state <= FCSS_ST_FIN;
                  if (op == FCSS_OP_CLEAR) o_seq_error <= 1'b0;
                  // One resume continues the nested program, the next the erase
                  if (op == FCSS_OP_RESUME) begin
                     if (o_prog_susp) o_prog_susp <= 1'b0;
                     else if (o_erase_susp && !prog_nest) o_erase_susp <= 1'b0;
                  end
               end
            end
            FCSS_ST_SECND: begin
               if (cyc_done) begin
                  state <= (engine_op && wait_rdy) ? FCSS_ST_POLL : FCSS_ST_FIN;
                  if (op == FCSS_OP_ERASE) erase_run <= 1'b1;
                  // Later requests overwrite addr, so the erased block is kept apart
                  if (op == FCSS_OP_ERASE) erase_blk <= addr[21:15];
                  if (op == FCSS_OP_PROGRAM && o_erase_susp) prog_nest <= 1'b1;
               end
            end
            FCSS_ST_POLL: begin
               if (cyc_done) begin
                  o_status <= poll_st;
                  o_rdata <= {8'h0, poll_st};
                  if (st_ready) begin
                     state <= FCSS_ST_FIN;
                     if (st_seqerr) o_seq_error <= 1'b1;
                     if (st_esusp && erase_run) o_erase_susp <= 1'b1;
                     if (st_psusp) o_prog_susp <= 1'b1;
                     // Ready without program suspend: the nested program has ended
                     if (!st_psusp && prog_nest) prog_nest <= 1'b0;
                     if (!st_esusp && !o_erase_susp) erase_run <= 1'b0;
                  end
               end
            end
            FCSS_ST_FIN: begin
               o_done <= 1'b1;
               state <= FCSS_ST_IDLE;
            end
            default: state <= FCSS_ST_IDLE;
         endcase
      end
   end

   assign o_nested = prog_nest;

   // Assertions
   // Output enable stays low for the rest of the strobe, then rises
   sequence s_strobe_tail;
      !o_oe_n ##1 o_oe_n;
   endsequence
   a_erase_susp_both: assert property (@(posedge i_clk) disable iff (!i_nrst)
      $rose(o_erase_susp) |-> $past(st_esusp)) else $error("erase suspend w/o bits");
   a_no_nested_erase: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_req && o_ready && req_op == FCSS_OP_ERASE && o_erase_susp) |=> o_refused)
      else $error("nested erase accepted");
   a_resume_blocked: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (i_req && o_ready && req_op == FCSS_OP_RESUME && o_erase_susp && prog_nest && !o_prog_susp)
      |=> o_refused) else $error("resume during nested program");
   a_status_masked: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_status[0] == 1'b0) else $error("reserved bit not masked");
   a_poll_toggle: assert property (@(posedge i_clk) disable iff (!i_nrst)
      $fell(o_oe_n) |=> s_strobe_tail) else $error("poll strobe");
   a_seq_error: assert property (@(posedge i_clk) disable iff (!i_nrst)
      $rose(o_seq_error) |-> $past(poll_st[4] && poll_st[5] && poll_st[7]))
      else $error("seq error w/o bits");
   a_prog_susp_both: assert property (@(posedge i_clk) disable iff (!i_nrst)
      $rose(o_prog_susp) |-> $past(st_psusp)) else $error("program suspend w/o bits");
   a_done_pulse: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_done |=> !o_done) else $error("done longer than a cycle");
endmodule

// File: hw/fcss_map.svh
// Command codes, status bit positions and bus timing counts for the flash controller
`ifndef FCSS_MAP_SVH
`define FCSS_MAP_SVH
`define FCSS_CMD_READ_ARRAY   8'hff
`define FCSS_CMD_READ_ID      8'h90
`define FCSS_CMD_QUERY        8'h98
`define FCSS_CMD_READ_STATUS  8'h70
`define FCSS_CMD_CLEAR_STATUS 8'h50
`define FCSS_CMD_PROG_SETUP   8'h40
`define FCSS_CMD_PROG_ALT     8'h10
`define FCSS_CMD_ERASE_SETUP  8'h20
`define FCSS_CMD_CONFIRM      8'hd0
`define FCSS_CMD_SUSPEND      8'hb0
`define FCSS_CMD_CFG_SETUP    8'h60
`define FCSS_CMD_LOCK         8'h01
`define FCSS_CMD_LOCKDOWN     8'h2f
`define FCSS_CMD_PROT_SETUP   8'hc0
`define FCSS_PROT_LOCK_DATA   16'hfffd
`define FCSS_BIT_READY        7
`define FCSS_BIT_ERASE_SUSP   6
`define FCSS_BIT_ERASE_FAIL   5
`define FCSS_BIT_PROG_FAIL    4
`define FCSS_BIT_SUPPLY_LOW   3
`define FCSS_BIT_PROG_SUSP    2
`define FCSS_BIT_LOCK_ABORT   1
`define FCSS_STATUS_MASK      8'hfe
// Strobe phase lengths, in ns and in 50 ns clock cycles (rounded up)
`define FCSS_CLK_NS           50
`define FCSS_STROBE_NS        100
`define FCSS_STROBE_CYC       ((`FCSS_STROBE_NS + `FCSS_CLK_NS - 1) / `FCSS_CLK_NS)
`define FCSS_GAP_NS           50
`define FCSS_GAP_CYC          ((`FCSS_GAP_NS + `FCSS_CLK_NS - 1) / `FCSS_CLK_NS)
`endif

// File: hw/fcss_pkg.sv
// Types shared by the flash command controller
package fcss_pkg;
   // User operations
   typedef enum logic [3:0] {
      FCSS_OP_READ_ARRAY = 4'h0,
      FCSS_OP_READ_ID    = 4'h1,
      FCSS_OP_QUERY      = 4'h2,
      FCSS_OP_STATUS     = 4'h3,
      FCSS_OP_CLEAR      = 4'h4,
      FCSS_OP_PROGRAM    = 4'h5,
      FCSS_OP_ERASE      = 4'h6,
      FCSS_OP_SUSPEND    = 4'h7,
      FCSS_OP_RESUME     = 4'h8,
      FCSS_OP_LOCK       = 4'h9,
      FCSS_OP_UNLOCK     = 4'ha,
      FCSS_OP_LOCKDOWN   = 4'hb,
      FCSS_OP_PROT_PROG  = 4'hc,
      FCSS_OP_PROT_LOCK  = 4'hd,
      FCSS_OP_READ       = 4'he
   } fcss_op_e;
   // Bus cycle sequencer states
   typedef enum logic [1:0] {
      FCSS_CYC_IDLE   = 2'b00,
      FCSS_CYC_STROBE = 2'b01,
      FCSS_CYC_GAP    = 2'b10
   } fcss_cyc_e;
endpackage

// File: hw/fcss_bus_cycle.sv
// One asynchronous flash bus cycle: a write or a read strobe with recovery gap
`timescale 1ns/1ns
`include "fcss_map.svh"
module fcss_bus_cycle
   import fcss_pkg::*;
(
   input  wire logic        i_clk,     // 20 MHz clock
   input  wire logic        i_nrst,    // Async reset, active low
   input  wire logic        i_start,   // Start a cycle, one pulse
   input  wire logic        i_write,   // 1 write, 0 read
   input  wire logic [21:0] i_addr,    // Word address
   input  wire logic [15:0] i_wdata,   // Write data
   input  wire logic [15:0] i_dq_in,   // Data pins in
   output logic             o_busy,    // Cycle in progress
   output logic             o_done,    // Cycle finished, one pulse
   output logic [15:0]      o_rdata,   // Data captured on a read
   output logic [21:0]      o_a,       // Address pins
   output logic [15:0]      o_dq_out,  // Data pins out
   output logic             o_dq_oe,   // High while driving data
   output logic             o_ce_n,    // Chip enable, active low
   output logic             o_oe_n,    // Output enable, active low
   output logic             o_we_n     // Write enable, active low
);
   fcss_cyc_e  state;        // Sequencer state
   logic [3:0] cnt;          // Phase counter
   logic       wr;           // Latched direction
   wire        phase_end = (cnt == 4'h0);
   // Strobes fall on entering the strobe phase and rise at its end, so each
   // status poll gets a fresh falling edge of output enable
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state <= FCSS_CYC_IDLE;
         cnt <= 4'h0;
         wr <= 1'b0;
         o_a <= 22'h0;
         o_dq_out <= 16'h0;
         o_dq_oe <= 1'b0;
         o_ce_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         o_rdata <= 16'h0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         case (state)
            FCSS_CYC_IDLE: begin
               if (i_start) begin
                  state <= FCSS_CYC_STROBE;
                  cnt <= 4'(`FCSS_STROBE_CYC - 1);
                  wr <= i_write;
                  o_a <= i_addr;
                  o_dq_out <= i_wdata;
                  o_dq_oe <= i_write;
                  o_ce_n <= 1'b0;
                  o_oe_n <= i_write;
                  o_we_n <= !i_write;
               end
            end
            FCSS_CYC_STROBE: begin
               if (phase_end) begin
                  // Sample read data before output enable rises
                  if (!wr) o_rdata <= i_dq_in;
                  o_ce_n <= 1'b1;
                  o_oe_n <= 1'b1;
                  o_we_n <= 1'b1;
                  state <= FCSS_CYC_GAP;
                  cnt <= 4'(`FCSS_GAP_CYC - 1);
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            FCSS_CYC_GAP: begin
               o_dq_oe <= 1'b0;
               if (phase_end) begin
                  state <= FCSS_CYC_IDLE;
                  o_done <= 1'b1;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            default: state <= FCSS_CYC_IDLE;
         endcase
      end
   end
   assign o_busy = (state != FCSS_CYC_IDLE);
endmodule

// File: tb/fcss_flash_model.sv
// Behavioural flash device: command decoder, write engine and status value
`timescale 1ns/1ns
module fcss_flash_model (
   input  wire logic [21:0] i_a,    // Address pins
   input  wire logic [15:0] i_dq,   // Data wire level
   input  wire logic        i_ce_n, // Chip enable, active low
   input  wire logic        i_oe_n, // Output enable, active low
   input  wire logic        i_we_n, // Write enable, active low
   output logic      [15:0] o_dq    // Data offered to the wire
);
   logic [7:0]   pend = 8'h00;  // Setup code awaiting its second write
   logic [1:0]   mode = 2'd0;   // 0 array, 1 status, 2 identifier, 3 query
   logic [127:0] lck = '0;      // Lock per block; starts unlocked to keep runs short
   logic         es = 0, ps = 0, ef = 0, pf = 0, lk = 0, vs = 0; // Status flags
   logic         low_sup = 0;                    // Programming supply out of range
   logic         ea = 0, pa = 0, esr = 0, psr = 0;       // Engine activity, suspend asks
   int           ec = 0, pc = 0;                         // Remaining engine ticks
   logic [21:0]  wa, last_a, pt, et;                    // Write, last second write, targets
   logic [15:0]  wd, last_d, rd = 16'h0000, hold = 16'h0000;
   logic         wv;                                     // Write was chip-selected
   wire          run = (pa && !ps) || (ea && !es && !pa);
   wire  [7:0]   sr = {!run, es, ef, pf, vs, ps, lk, 1'b1};
   // Suspends land on the next tick, a fixed point of the algorithm
   always #50 begin
      if (psr) {ps, psr} = 2'b10;
      else if (esr) {es, esr} = 2'b10;
      else if (pa && !ps) begin
         {pa, pc} = {pc > 1, pc - 1};
         // Supply checked again before verify; a marked word never programs
         if (!pa) {vs, pf} = {vs | low_sup, pf | (pt[7:0] == 8'hee)};
      end
      else if (ea && !es && !pa) begin
         {ea, ec} = {ec > 1, ec - 1};
         // A marked block still fails verify after the last pulse
         if (!ea) {vs, ef} = {vs | low_sup, ef | (et[21:15] == 7'h7e)};
      end
   end
   task automatic start(input logic er, input logic bad);
      if (bad) {ef, pf} = 2'b11;
      else if (lck[wa[21:15]]) lk = 1'b1;
      else if (low_sup) {vs, ef} = {1'b1, er | ef};
      else if (er) {ea, ec, et} = {1'b1, 32'd300, wa};
      else {pa, pc, pt} = {1'b1, 32'd40, wa};
   endtask
   task automatic wr();
      logic [7:0] c;
      c = wd[7:0];
      if (pend != 8'h00) begin
         {last_a, last_d, mode} = {wa, wd, 2'd1};
         case (pend)
            8'h40, 8'h10: start(1'b0, 1'b0);
            8'h20: start(1'b1, c != 8'hd0 || es);
            8'h60: lck[wa[21:15]] = (c != 8'hd0);
            default: ; // Protection writes finish at once
         endcase
         pend = 8'h00;
      end
      else case (c)
         8'h40, 8'h10, 8'h20, 8'h60, 8'hc0: pend = c;
         8'hff: mode = 2'd0;
         8'h70: mode = 2'd1;
         8'h90: mode = 2'd2;
         8'h98: mode = 2'd3;
         8'h50: {ef, pf, lk, vs} = 4'b0000;
         8'hb0: {psr, esr, mode} = {pa && !ps, ea && !es && !pa, 2'd1};
         8'hd0: {ps, es, mode} = {1'b0, ps ? es : es && pa, 2'd1};
         default: {ef, pf} = 2'b11;
      endcase
   endtask
   // Latch the write after the strobe settles, act on its rising edge
   always @(negedge i_we_n) begin
      #1;
      {wa, wd, wv} = {i_a, i_dq, !i_ce_n};
   end
   always @(posedge i_we_n) if (wv) wr();
   // Read value fixed at the later falling enable, so a poll sees one snapshot
   always @(negedge i_oe_n or negedge i_ce_n) begin
      #1;
      case (mode)
         2'd0: rd = i_a[15:0] ^ 16'h5a5a;
         2'd1: rd = {8'h00, sr};
         2'd2: rd = 16'h0100 | {8'h00, i_a[7:0]};
         default: rd = 16'h0200 | {8'h00, i_a[7:0]};
      endcase
   end
   // A released bus shows the inverse of the last value, never stale data
   always @(posedge i_oe_n) hold = ~rd;
   assign o_dq = (!i_ce_n && !i_oe_n) ? rd : hold;
endmodule

// File: tb/testbench.sv
// Self-checking bench for the flash command controller against a device model
`timescale 1ns/1ns
module testbench
   import fcss_pkg::*;
;
   logic        i_clk = 0, i_nrst = 0, i_req = 0, i_wait = 0, ok;
   logic [3:0]  i_op = 4'h0;
   logic [21:0] i_addr = 22'h000000, o_a;
   logic [15:0] i_data = 16'h0000, o_rdata, o_dq_out, dev_dq;
   logic [7:0]  o_status;
   logic        o_ready, o_done, o_refused, o_erase_susp, o_prog_susp, o_seq_error;
   logic        o_nested, o_dq_oe, o_ce_n, o_oe_n, o_we_n;
   wire  [15:0] bus = o_dq_oe ? o_dq_out : dev_dq; // Shared data wire
   int          mismatches = 0, checked = 0;
   fcss_ctrl fcss_ctrl_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .i_op(i_op),
      .i_addr(i_addr), .i_data(i_data), .i_wait(i_wait), .o_ready(o_ready),
      .o_done(o_done), .o_refused(o_refused), .o_rdata(o_rdata), .o_status(o_status),
      .o_erase_susp(o_erase_susp), .o_prog_susp(o_prog_susp), .o_seq_error(o_seq_error),
      .o_nested(o_nested), .o_a(o_a), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
      .i_dq_in(bus), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n));
   fcss_flash_model fcss_flash_model_i (.i_a(o_a), .i_dq(bus), .i_ce_n(o_ce_n),
      .i_oe_n(o_oe_n), .i_we_n(o_we_n), .o_dq(dev_dq));
   initial forever #25 i_clk = ~i_clk;
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // One request, launched at a falling edge; waits for done or refused
   task automatic req(input logic [3:0] op, input logic [21:0] ad, input logic [15:0] d,
                      input logic w);
      int n;
      chk("ready", 1, o_ready);
      {i_req, i_op, i_addr, i_data, i_wait} = {1'b1, op, ad, d, w};
      @(negedge i_clk);
      i_req = 0;
      for (n = 0; n < 5000 && o_done !== 1'b1 && o_refused !== 1'b1; n++) @(negedge i_clk);
      ok = o_done;
      if (n == 5000) begin
         mismatches++;
         summarize();
      end
   endtask
   task automatic t_prog();
      req(FCSS_OP_PROGRAM, 22'h008123, 16'h1234, 1);
      chk("program word", 16'h1234, fcss_flash_model_i.last_d);
      chk("program addr", 16'h8123, fcss_flash_model_i.last_a[15:0]);
      chk("status", 16'h0080, o_status);
      chk("upper byte", 16'h0000, o_rdata[15:8]);
      $display("test program done");
   endtask
   task automatic t_susp();
      req(FCSS_OP_ERASE, 22'h010000, 16'h0000, 0);
      chk("erase running", 1, fcss_flash_model_i.ea);
      req(FCSS_OP_SUSPEND, 22'h3fffff, 16'h0000, 1);
      chk("erase suspended", 1, o_erase_susp);
      chk("status", 16'h00c0, o_status);
      req(FCSS_OP_ERASE, 22'h018000, 16'h0000, 0);
      chk("nested erase", 0, ok);
      req(FCSS_OP_PROGRAM, 22'h010004, 16'h0055, 0);
      chk("same block", 0, ok);
      req(FCSS_OP_PROGRAM, 22'h018004, 16'h0055, 0);
      chk("nested program", 1, o_nested);
      req(FCSS_OP_RESUME, 22'h000000, 16'h0000, 0);
      chk("early resume", 0, ok);
      req(FCSS_OP_SUSPEND, 22'h000000, 16'h0000, 1);
      chk("program suspended", 1, o_prog_susp);
      chk("status", 16'h00c4, o_status);
      req(FCSS_OP_RESUME, 22'h2a5555, 16'h0000, 1);
      chk("program resumed", 16'h00c0, o_status);
      chk("nested over", 0, o_nested);
      req(FCSS_OP_RESUME, 22'h15aaaa, 16'h0000, 1);
      chk("erase finished", 16'h0080, o_status);
      chk("suspend cleared", 0, o_erase_susp);
      $display("test suspend done");
   endtask
   task automatic t_lock();
      logic [3:0]  ops [3] = '{FCSS_OP_LOCK, FCSS_OP_UNLOCK, FCSS_OP_LOCKDOWN};
      logic [15:0] cod [3] = '{16'h0001, 16'h00d0, 16'h002f};
      for (int i = 0; i < 3; i++) begin
         req(ops[i], 22'h020000, 16'h0000, 0);
         chk("config code", cod[i], fcss_flash_model_i.last_d[7:0]);
         chk("lock state", i != 1, fcss_flash_model_i.lck[4]);
      end
      req(FCSS_OP_PROGRAM, 22'h020001, 16'h0f0f, 1);
      chk("lock abort", 16'h0082, o_status);
      req(FCSS_OP_STATUS, 22'h000000, 16'h0000, 0);
      req(FCSS_OP_READ, 22'h000000, 16'h0000, 0);
      chk("abort held", 16'h0082, o_rdata & 16'hfffe);
      req(FCSS_OP_CLEAR, 22'h000000, 16'h0000, 0);
      req(FCSS_OP_STATUS, 22'h000000, 16'h0000, 0);
      req(FCSS_OP_READ, 22'h000000, 16'h0000, 0);
      chk("cleared", 16'h0080, o_rdata & 16'hfffe);
      $display("test lock done");
   endtask
   task automatic t_fail();
      fcss_flash_model_i.low_sup = 1'b1;
      req(FCSS_OP_PROGRAM, 22'h000100, 16'h0000, 1);
      chk("supply low", 16'h0088, o_status);
      fcss_flash_model_i.low_sup = 1'b0;
      req(FCSS_OP_ERASE, 22'h3f0000, 16'h0000, 1);
      chk("erase fail", 16'h00a8, o_status);
      req(FCSS_OP_PROGRAM, 22'h0000ee, 16'h0000, 1);
      chk("program fail", 16'h00b8, o_status);
      chk("seq error", 1, o_seq_error);
      req(FCSS_OP_CLEAR, 22'h000000, 16'h0000, 0);
      chk("seq cleared", 0, o_seq_error);
      $display("test fail done");
   endtask
   task automatic t_reads();
      logic [3:0]  ops [3] = '{FCSS_OP_READ_ID, FCSS_OP_QUERY, FCSS_OP_READ_ARRAY};
      logic [15:0] exp [3] = '{16'h0101, 16'h0210, 16'h1234 ^ 16'h5a5a};
      logic [21:0] ad [3] = '{22'h000001, 22'h000010, 22'h001234};
      for (int i = 0; i < 3; i++) begin
         req(ops[i], 22'h3f0000, 16'h0000, 0);
         req(FCSS_OP_READ, ad[i], 16'h0000, 0);
         chk("read data", exp[i], o_rdata);
      end
      req(FCSS_OP_PROT_PROG, 22'h000081, 16'hbeef, 0);
      chk("prot word", 16'hbeef, fcss_flash_model_i.last_d);
      req(FCSS_OP_PROT_LOCK, 22'h000080, 16'h0000, 0);
      chk("prot lock", 16'hfffd, fcss_flash_model_i.last_d);
      req(4'hf, 22'h000000, 16'h0000, 0);
      chk("bad op", 1, o_refused);
      $display("test reads done");
   endtask
   initial begin
      repeat (16) @(negedge i_clk);
      i_nrst = 1;
      @(negedge i_clk);
      chk("idle pins", 16'h0007, {o_dq_oe, o_ce_n, o_oe_n, o_we_n});
      t_prog();
      t_susp();
      t_lock();
      t_fail();
      t_reads();
      summarize();
   end
endmodule
